/* nc_defs.svh */
`ifndef NC_DEFS_SVH
`define NC_DEFS_SVH
// ----------------------------------------------------------
// Register offsets
// ----------------------------------------------------------
`define NC_OFF_INSTR 12'h000
`define NC_OFF_STATE 12'h004
`define NC_OFF_MEM   12'h008
`define NC_OFF_PORTS 12'h00c
// ----------------------------------------------------------
// Opcodes and masks
// ----------------------------------------------------------
`define NC_OP_NOP  10'h000
`define NC_OP_POF  10'h002
`define NC_OP_INY  10'h013
`define NC_OP_OR   10'h019
`define NC_OP_RAR  10'h01d
`define NC_OP_POWER_DOWN_ARM 10'h05b
`define NC_OP_LZ   10'h048
`define NC_OP_RB   10'h04c
`define NC_OP_LA   10'h070
`define NC_OP_LXY  10'h300
`define NC_OP_OUT  10'h220
`define NC_MSK_LZ  10'h3fc
`define NC_MSK_LA  10'h3f0
`define NC_MSK_LXY 10'h300
`define NC_MSK_OUT 10'h3f8
`define NC_LAST_PORT 3'h6
// ----------------------------------------------------------
// State register field positions and reset values
// ----------------------------------------------------------
`define NC_ST_A    0
`define NC_ST_CY   4
`define NC_ST_X    8
`define NC_ST_Y    12
`define NC_ST_Z    16
`define NC_ST_SKIP 18
`define NC_ST_BKUP 19
`define NC_ST_ARM  20
`define NC_RST_NIB 4'h0
`define NC_RST_Z   2'h0
`endif

/* nc_pkg.sv */
package nc_pkg;
  // Decoded instruction class
  typedef enum logic [3:0] {
    K_NOP, K_POF, K_INY, K_OR, K_RAR, K_POWER_DOWN_ARM,
    K_LZ, K_RB, K_LA, K_LXY, K_OUT, K_OTHER
  } nc_kind_t;
  // Core register set
  typedef struct packed {
    logic [3:0] a;
    logic       cy;
    logic [3:0] x;
    logic [3:0] y;
    logic [1:0] z;
  } nc_core_t;
endpackage

/* nc_core.sv */
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "nc_defs.svh"
module nc_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [27:0] port_out,
  output logic             backup_mode
);
  // ----------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------
  // Classify a 10-bit instruction word
  function automatic nc_pkg::nc_kind_t decode_kind(input logic [9:0] op);
    nc_pkg::nc_kind_t k;
    k = nc_pkg::K_OTHER;
    case (op)
      `NC_OP_NOP:  k = nc_pkg::K_NOP;
      `NC_OP_POF:  k = nc_pkg::K_POF;
      `NC_OP_INY:  k = nc_pkg::K_INY;
      `NC_OP_OR:   k = nc_pkg::K_OR;
      `NC_OP_RAR:  k = nc_pkg::K_RAR;
      `NC_OP_POWER_DOWN_ARM: k = nc_pkg::K_POWER_DOWN_ARM;
      default: begin
        if ((op & `NC_MSK_LXY) == `NC_OP_LXY) begin
          k = nc_pkg::K_LXY;
        end else if ((op & `NC_MSK_LA) == `NC_OP_LA) begin
          k = nc_pkg::K_LA;
        end else if ((op & `NC_MSK_LZ) == `NC_OP_LZ) begin
          k = nc_pkg::K_LZ;
        end else if ((op & `NC_MSK_LZ) == `NC_OP_RB) begin
          k = nc_pkg::K_RB;
        end else if ((op & `NC_MSK_OUT) == `NC_OP_OUT &&
                     op[2:0] <= `NC_LAST_PORT) begin
          k = nc_pkg::K_OUT;
        end
      end
    endcase
    return k;
  endfunction

  // Offset decode, used by the error path only
  function automatic logic mapped(input logic [11:0] addr);
    return (addr == `NC_OFF_INSTR) || (addr == `NC_OFF_STATE) ||
           (addr == `NC_OFF_MEM)   || (addr == `NC_OFF_PORTS);
  endfunction

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  localparam int NPORT = 7;                // Output ports
  localparam int MDEPTH = 1024;            // Nibbles addressed by Z:X:Y
  nc_pkg::nc_core_t  core_q;               // A, carry, X, Y, Z
  logic              skip_q;               // Next instruction skipped
  logic              prev_la_q;            // Last word was acc load
  logic              prev_lxy_q;           // Last word was pair load
  logic              arm_q;                // Power-down armed
  logic              backup_q;             // RAM back-up mode
  logic [9:0]        last_op_q;            // Last instruction word
  logic [31:0]       prdata_q;             // Read data, taken at setup
  logic [3:0]        port_q [NPORT];       // Port output latches
  logic [3:0]        mem_q [MDEPTH];       // Data memory
  logic              wr_acc;               // Write access phase
  logic              go;                   // Instruction issued
  logic              chain;                // Repeated load suppressed
  logic              run;                  // Instruction takes effect
  logic [9:0]        op;                   // Instruction word
  nc_pkg::nc_kind_t  kind;                 // Decoded class
  logic [9:0]        dp;                   // Data pointer
  logic [3:0]        mem_rd;               // Pointed nibble

  // ----------------------------------------------------------
  // Bus decode and issue
  // ----------------------------------------------------------
  assign wr_acc  = psel & penable & pwrite;
  assign op      = pwdata[9:0];
  assign kind    = decode_kind(op);
  // Issue only while awake
  assign go      = wr_acc && (paddr == `NC_OFF_INSTR) && !backup_q;
  // Back-to-back acc loads or pair loads after the first do nothing
  assign chain   = (kind == nc_pkg::K_LA && prev_la_q) ||
                   (kind == nc_pkg::K_LXY && prev_lxy_q);
  assign run     = go && !skip_q && !chain;
  assign dp      = {core_q.z, core_q.x, core_q.y};
  assign mem_rd  = mem_q[dp];
  assign pready  = 1'b1;
  assign pslverr = psel & penable & !mapped(paddr);
  assign prdata  = prdata_q;
  assign backup_mode = backup_q;

  // ----------------------------------------------------------
  // Read data, registered in the setup cycle
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (psel && !penable) begin
      prdata_q <= 32'h0;
      case (paddr)
        `NC_OFF_INSTR: prdata_q[9:0] <= last_op_q;
        `NC_OFF_STATE: begin
          prdata_q[`NC_ST_A +: 4]   <= core_q.a;
          prdata_q[`NC_ST_CY]       <= core_q.cy;
          prdata_q[`NC_ST_X +: 4]   <= core_q.x;
          prdata_q[`NC_ST_Y +: 4]   <= core_q.y;
          prdata_q[`NC_ST_Z +: 2]   <= core_q.z;
          prdata_q[`NC_ST_SKIP]     <= skip_q;
          prdata_q[`NC_ST_BKUP]     <= backup_q;
          prdata_q[`NC_ST_ARM]      <= arm_q;
        end
        `NC_OFF_MEM:   prdata_q[3:0] <= mem_rd;
        `NC_OFF_PORTS: prdata_q[27:0] <= port_out;
        default:       prdata_q <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Core registers
  // ----------------------------------------------------------
  // Execute one instruction per issue, or software load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_q <= '0;
    end else if (run) begin
      case (kind)
        nc_pkg::K_INY: core_q.y <= 4'(core_q.y + 4'h1);
        nc_pkg::K_LA:  core_q.a <= op[3:0];
        nc_pkg::K_LXY: begin
          core_q.x <= op[7:4];
          core_q.y <= op[3:0];
        end
        nc_pkg::K_LZ:  core_q.z <= op[1:0];
        nc_pkg::K_OR:  core_q.a <= core_q.a | mem_rd;
        nc_pkg::K_RAR: begin
          core_q.a  <= {core_q.cy, core_q.a[3:1]};
          core_q.cy <= core_q.a[0];
        end
        // No-operation and others leave state alone
        default: core_q <= core_q;
      endcase
    end else if (wr_acc && paddr == `NC_OFF_STATE) begin
      core_q.a  <= pwdata[`NC_ST_A +: 4];
      core_q.cy <= pwdata[`NC_ST_CY];
      core_q.x  <= pwdata[`NC_ST_X +: 4];
      core_q.y  <= pwdata[`NC_ST_Y +: 4];
      core_q.z  <= pwdata[`NC_ST_Z +: 2];
    end
  end

  // ----------------------------------------------------------
  // Sequencing flags
  // ----------------------------------------------------------
  // Skip after a wrapping Y increment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_q <= 1'b0;
    end else if (go) begin
      skip_q <= run && kind == nc_pkg::K_INY && core_q.y == 4'hf;
    end
  end

  // Track repeated loads by word, skipped or not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_la_q  <= 1'b0;
      prev_lxy_q <= 1'b0;
      last_op_q  <= 10'h000;
    end else if (go) begin
      prev_la_q  <= kind == nc_pkg::K_LA;
      prev_lxy_q <= kind == nc_pkg::K_LXY;
      last_op_q  <= op;
    end
  end

  // Arm holds for exactly the next instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_q <= 1'b0;
    end else if (go) begin
      arm_q <= run && kind == nc_pkg::K_POWER_DOWN_ARM;
    end
  end

  // Back-up mode; software wakes via state write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      backup_q <= 1'b0;
    end else if (run && kind == nc_pkg::K_POF && arm_q) begin
      // Unarmed power-down falls through as no-operation
      backup_q <= 1'b1;
    end else if (wr_acc && paddr == `NC_OFF_STATE) begin
      backup_q <= pwdata[`NC_ST_BKUP];
    end
  end

  // ----------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------
  // Bit clear and software write; no reset on storage
  always_ff @(posedge pclk) begin
    if (run && kind == nc_pkg::K_RB) begin
      mem_q[dp][op[1:0]] <= 1'b0;
    end else if (wr_acc && paddr == `NC_OFF_MEM) begin
      mem_q[dp] <= pwdata[3:0];
    end
  end

  // ----------------------------------------------------------
  // Output ports
  // ----------------------------------------------------------
  for (genvar i = 0; i < NPORT; i++) begin : g_port
    // Latch accumulator on matching port opcode
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        port_q[i] <= `NC_RST_NIB;
      end else if (run && kind == nc_pkg::K_OUT && op[2:0] == 3'(i)) begin
        port_q[i] <= core_q.a;
      end
    end
    assign port_out[4*i +: 4] = port_q[i];
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_iny_incr: assert property (
    run && kind == nc_pkg::K_INY |=> core_q.y == 4'($past(core_q.y) + 4'h1))
    else $error("Y not incremented");
  chk_iny_skip: assert property (
    run && kind == nc_pkg::K_INY && core_q.y == 4'hf |=> skip_q)
    else $error("Wrap did not arm skip");
  chk_la_load: assert property (
    run && kind == nc_pkg::K_LA |=> core_q.a == $past(op[3:0]))
    else $error("Acc load wrong");
  chk_la_chain: assert property (
    go && kind == nc_pkg::K_LA && prev_la_q |=> $stable(core_q))
    else $error("Repeated acc load took effect");
  chk_lxy_load: assert property (
    run && kind == nc_pkg::K_LXY
    |=> core_q.x == $past(op[7:4]) && core_q.y == $past(op[3:0]))
    else $error("Pair load wrong");
  chk_lz_load: assert property (
    run && kind == nc_pkg::K_LZ
    |=> core_q.z == $past(op[1:0]) && core_q.a == $past(core_q.a))
    else $error("Bank load wrong");
  chk_nop_quiet: assert property (
    go && kind == nc_pkg::K_NOP |=> $stable(core_q) && $stable(port_out))
    else $error("No-operation changed state");
  chk_port_out: assert property (
    run && kind == nc_pkg::K_OUT
    |=> port_out[4*$past(op[2:0]) +: 4] == $past(core_q.a))
    else $error("Port not driven");
  chk_or_acc: assert property (
    run && kind == nc_pkg::K_OR |=> core_q.a == ($past(core_q.a) | $past(mem_rd)))
    else $error("OR result wrong");
  chk_pof_armed: assert property (
    run && kind == nc_pkg::K_POF && arm_q |=> backup_q)
    else $error("Armed power-down ignored");
  chk_pof_unarmed: assert property (
    go && kind == nc_pkg::K_POF && !arm_q && !backup_q |=> !backup_q)
    else $error("Unarmed power-down acted");
  chk_rar_ring: assert property (
    run && kind == nc_pkg::K_RAR
    |=> core_q.cy == $past(core_q.a[0]) && core_q.a[3] == $past(core_q.cy))
    else $error("Rotate wrong");
  chk_rb_clear: assert property (
    run && kind == nc_pkg::K_RB
    |=> mem_q[$past(dp)] == ($past(mem_rd) & ~(4'h1 << $past(op[1:0]))))
    else $error("Bit clear wrong");
  chk_carry_only: assert property (
    go && kind != nc_pkg::K_RAR |=> $stable(core_q.cy))
    else $error("Carry changed");
  chk_skip_quiet: assert property (
    go && skip_q |=> $stable(core_q) && $stable(port_out) && !skip_q)
    else $error("Skipped word had effect");

  cov_wrap_skip: cover property (
    run && kind == nc_pkg::K_INY && core_q.y == 4'hf ##[1:8] go && skip_q);
  cov_la_chain: cover property (go && kind == nc_pkg::K_LA && prev_la_q);
  cov_backup: cover property (run && kind == nc_pkg::K_POF && arm_q);
  cov_port_six: cover property (run && kind == nc_pkg::K_OUT && op[2:0] == 3'h6);
endmodule // nc_core

/* nc_port_pins.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------
// Port pin model: the levels the outside world sees
// ----------------------------------------------------------
module nc_port_pins (
  port_out,
  backup_mode,
  pin_level
);
  input  wire logic [27:0] port_out;     // Seven output nibbles
  input  wire logic        backup_mode;  // Back-up state, pins keep levels
  output logic      [27:0] pin_level;    // Levels on the seven ports

  // Pins follow the port latches, nibble n on port n
  always_comb begin
    pin_level = port_out;
  end
endmodule // nc_port_pins

/* nc_bench.sv */
`timescale 1ns/100ps
`include "nc_defs.svh"
// ----------------------------------------------------------
// Bench for the instruction subset, over APB
// ----------------------------------------------------------
module nibble_cpu_instr_subset_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, backup_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [27:0] port_out, pin_level, pexp;  // Ports, pins, expected ports
  logic [3:0]  a, x, y;                    // Expected core nibbles
  logic        cy;                         // Expected carry
  logic [1:0]  z;                          // Expected bank pointer
  logic [32:0] q[$];                       // Expected {pslverr, prdata}
  int          seed, n_errors, cmp_count;

  nc_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_out(port_out), .backup_mode(backup_mode));
  nc_port_pins pins (.port_out(port_out), .backup_mode(backup_mode), .pin_level(pin_level));

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Verdict and closing report
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Compare one value
  task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= ad; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin n_errors++; end_sim(); end
      @(posedge pclk);
    end
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Issue one instruction word
  task automatic ex(input logic [9:0] op);
    apb(1'b1, `NC_OFF_INSTR, {22'h0, op});
  endtask

  // Read with an expected value noted first
  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    q.push_back({1'b0, e});
    apb(1'b0, ad, 32'h0);
  endtask

  // Expected state word from the bench copy of the core
  function automatic logic [31:0] sw(input logic sk, input logic bk, input logic ar);
    sw = 32'h0;
    sw[`NC_ST_A +: 4] = a; sw[`NC_ST_CY] = cy; sw[`NC_ST_X +: 4] = x;
    sw[`NC_ST_Y +: 4] = y; sw[`NC_ST_Z +: 2] = z;
    sw[`NC_ST_SKIP] = sk; sw[`NC_ST_BKUP] = bk; sw[`NC_ST_ARM] = ar;
  endfunction

  // Read checker: oldest note against each completed read
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (q.size() == 0) begin n_errors++; $display("CHECK FAILED queue expected note seen none"); end
      else cmp("read", q.pop_front(), {pslverr, prdata});
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_sim();
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {a, x, y, cy, z, pexp} = '0;
    seed = 32086; n_errors = 0; cmp_count = 0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`NC_OFF_STATE, sw(0, 0, 0));
    rd(`NC_OFF_PORTS, 32'h0);
    $display("reset done");
    // Load chains
    ex(`NC_OP_LA | 10'h5); ex(`NC_OP_LA | 10'h9); a = 4'h5;
    rd(`NC_OFF_STATE, sw(0, 0, 0));
    ex(`NC_OP_NOP); ex(`NC_OP_LA | 10'h9); a = 4'h9;
    rd(`NC_OFF_STATE, sw(0, 0, 0));
    ex(`NC_OP_LXY | 10'h3f); ex(`NC_OP_LXY | 10'h11); x = 4'h3; y = 4'hf;
    rd(`NC_OFF_STATE, sw(0, 0, 0));
    $display("load chain done");
    // Increment with skip on wrap
    ex(`NC_OP_INY); y = 4'h0;
    rd(`NC_OFF_STATE, sw(1, 0, 0));
    ex(`NC_OP_LA | 10'h2); ex(`NC_OP_INY); y = 4'h1;
    ex(`NC_OP_LA | 10'h7); a = 4'h7;
    rd(`NC_OFF_STATE, sw(0, 0, 0));
    for (int i = 0; i < 4; i++) begin
      ex(`NC_OP_LZ | 10'(i)); z = 2'(i);
      rd(`NC_OFF_STATE, sw(0, 0, 0));
    end
    $display("skip and bank done");
    // Memory through the data pointer
    apb(1'b1, `NC_OFF_MEM, 32'h6);
    ex(`NC_OP_INY); apb(1'b1, `NC_OFF_MEM, 32'h9);
    ex(`NC_OP_LXY | 10'h31); y = 4'h1;
    rd(`NC_OFF_MEM, 32'h6);
    ex(`NC_OP_LA | 10'h1); ex(`NC_OP_OR); a = 4'h7;
    rd(`NC_OFF_STATE, sw(0, 0, 0));
    for (int j = 0; j < 4; j++) begin
      apb(1'b1, `NC_OFF_MEM, 32'hf); ex(`NC_OP_RB | 10'(j));
      rd(`NC_OFF_MEM, 32'hf & ~(32'h1 << j));
    end
    $display("memory done");
    // Rotate through carry, random start
    repeat (6) begin
      r = $random(seed); a = r[3:0]; cy = r[4];
      apb(1'b1, `NC_OFF_STATE, sw(0, 0, 0)); ex(`NC_OP_RAR);
      {a, cy} = {cy, a};
      rd(`NC_OFF_STATE, sw(0, 0, 0));
    end
    $display("rotate done");
    // Port outputs 0 to 6
    for (int n = 0; n <= 6; n++) begin
      ex(`NC_OP_LA | 10'(n + 9)); a = 4'(n + 9);
      ex(`NC_OP_OUT | 10'(n)); pexp[4*n +: 4] = a;
      @(negedge pclk);
      cmp("pins", {5'h0, pexp}, {5'h0, pin_level});
    end
    rd(`NC_OFF_PORTS, {4'h0, pexp});
    $display("ports done");
    // Power-down, unarmed then armed
    ex(`NC_OP_POF); @(negedge pclk);
    cmp("backup", 33'h0, {32'h0, backup_mode});
    ex(`NC_OP_POWER_DOWN_ARM);
    rd(`NC_OFF_STATE, sw(0, 0, 1));
    ex(`NC_OP_POF); @(negedge pclk);
    cmp("backup", 33'h1, {32'h0, backup_mode});
    ex(`NC_OP_LA | 10'h1);
    apb(1'b1, `NC_OFF_STATE, sw(0, 0, 0));
    rd(`NC_OFF_STATE, sw(0, 0, 0));
    q.push_back({1'b1, 32'h0});
    apb(1'b0, 12'h010, 32'h0);
    $display("power and unmapped done");
    repeat (2) @(posedge pclk);
    end_sim();
  end
endmodule // nibble_cpu_instr_subset_bench
